//--- fieldbus_state_fault_reporter.sv
// Fault detector and reporter for the fieldbus slave state machine
// Function
// - Impossible transition request raises 81/1 in any state, LED blinks.
// - Request to undefined state raises 81/2 in any state, LED blinks.
// - After 81/1 or 81/2 keep state below safe-op, else fall to safe-op.
// - Bootstrap request from init raises 81/3, LED flickers, go to init.
// - Firmware mismatch in boot or init raises 81/4, LED off, stay.
// - Mailbox not bootstrap-capable on init-to-boot raises 81/5, blink, init.
// - Bad mailbox sync-manager config in preop raises 81/6, blink, init.
// - File-transfer write failure in boot raises 80/5, LED off, stay.
// - Description file mismatch in init raises 80/6, LED off, stay.
module fieldbus_state_fault_reporter
(
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire fault_reporter_pkg::state_req_t req,
	input  wire fault_reporter_pkg::check_t     checks,
	input  wire logic                           fault_clear,
	output logic [3:0]                          slave_state,
	output fault_reporter_pkg::fault_t          fault,
	output fault_reporter_pkg::led_mode_t       led_mode,
	output logic [19:0]                         display,
	output logic                                fault_pulse
);
	import fault_reporter_pkg::*;

	logic [3:0]  next_slave_state;
	fault_t      next_fault;
	led_mode_t   next_led_mode;
	logic [19:0] next_display;
	logic        next_fault_pulse;
	logic        hit;
	logic [7:0]  hit_main;
	logic [3:0]  hit_sub;
	logic        known;
	logic        legal;

	// Legal transitions of the slave state machine
	function automatic logic legal_step(input logic [3:0] from, input logic [3:0] to);
		logic ok;
		ok = 1'b0;
		case (from)
			ST_INIT: ok = (to == ST_INIT) || (to == ST_PREOP) || (to == ST_BOOT);
			ST_PREOP: ok = (to == ST_INIT) || (to == ST_PREOP) || (to == ST_SAFEOP);
			ST_BOOT: ok = (to == ST_INIT) || (to == ST_BOOT);
			ST_SAFEOP: ok = (to == ST_INIT) || (to == ST_PREOP) || (to == ST_SAFEOP) || (to == ST_OP);
			ST_OP: ok = (to != ST_BOOT);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : legal_step

	always_comb
	begin
		known = (req.target == ST_INIT) || (req.target == ST_PREOP) || (req.target == ST_BOOT)
			|| (req.target == ST_SAFEOP) || (req.target == ST_OP);
		legal = legal_step(slave_state, req.target);
		next_slave_state = slave_state;
		next_led_mode = led_mode;
		hit = 1'b1;
		hit_main = MAIN_81;
		hit_sub = SUB_1;
		if (checks.firmware_mismatch && (slave_state == ST_BOOT || slave_state == ST_INIT))
		begin
			hit_sub = SUB_4;
			next_led_mode = LED_OFF;
		end
		else if (checks.file_write_fail && slave_state == ST_BOOT)
		begin
			hit_main = MAIN_80;
			hit_sub = SUB_5;
			next_led_mode = LED_OFF;
		end
		else if (checks.description_mismatch && slave_state == ST_INIT)
		begin
			hit_main = MAIN_80;
			hit_sub = SUB_6;
			next_led_mode = LED_OFF;
		end
		else if (checks.sm_mailbox_bad && slave_state == ST_PREOP)
		begin
			hit_sub = SUB_6;
			next_led_mode = LED_BLINK;
			next_slave_state = ST_INIT;
		end
		else if (req.valid && !known)
		begin
			hit_sub = SUB_2;
			next_led_mode = LED_BLINK;
			if (slave_state == ST_OP)
				next_slave_state = ST_SAFEOP;
		end
		else if (req.valid && req.target == ST_BOOT && slave_state == ST_INIT && checks.boot_mailbox_bad)
		begin
			hit_sub = SUB_5;
			next_led_mode = LED_BLINK;
			next_slave_state = ST_INIT;
		end
		else if (req.valid && req.target == ST_BOOT && slave_state == ST_INIT)
		begin
			hit_sub = SUB_3;
			next_led_mode = LED_FLICKER;
			next_slave_state = ST_INIT;
		end
		else if (req.valid && !legal)
		begin
			hit_sub = SUB_1;
			next_led_mode = LED_BLINK;
			if (slave_state == ST_OP)
				next_slave_state = ST_SAFEOP;
		end
		else
		begin
			hit = 1'b0;
			if (req.valid)
				next_slave_state = req.target;
		end
		next_fault = fault;
		// A fault found in the same cycle wins over the clear
		if (fault_clear && !hit)
		begin
			next_fault = '0;
			next_led_mode = LED_OFF;
		end
		if (hit)
		begin
			next_fault.active = 1'b1;
			next_fault.main_code = hit_main;
			next_fault.sub_code = hit_sub;
		end
		next_fault_pulse = hit;
		next_display = {CH_E, CH_R, 1'b0, next_fault.main_code[7:4], 1'b0, next_fault.main_code[3:0]};
		if (next_fault.active)
			next_display = {CH_E, CH_R, 1'b0, next_fault.main_code[7:4], 1'b0, next_fault.sub_code};
		else
			next_display = {CH_BLANK, CH_BLANK, CH_BLANK, CH_BLANK};
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slave_state <= ST_INIT;
			fault <= '0;
			led_mode <= LED_OFF;
			display <= {CH_BLANK, CH_BLANK, CH_BLANK, CH_BLANK};
			fault_pulse <= 1'b0;
		end
		else
		begin
			slave_state <= next_slave_state;
			fault <= next_fault;
			led_mode <= next_led_mode;
			display <= next_display;
			fault_pulse <= next_fault_pulse;
		end
	end

	invalid_fallback_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && !legal && known && !(slave_state == ST_INIT && req.target == ST_BOOT)
		&& !(|checks) && slave_state == ST_OP) |=> (slave_state == ST_SAFEOP && fault.sub_code == SUB_1))
		else $error("invalid request did not fall to safe-op");
	unknown_code_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && !known && !(|checks)) |=> (fault.main_code == MAIN_81 && fault.sub_code == SUB_2
		&& led_mode == LED_BLINK))
		else $error("unknown request not reported");
	unknown_fallback_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && !known && !(|checks) && slave_state == ST_OP) |=> (slave_state == ST_SAFEOP))
		else $error("unknown request did not fall to safe-op");
	unknown_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && !known && !(|checks) && slave_state != ST_OP) |=> (slave_state == $past(slave_state)))
		else $error("unknown request changed a low state");
	boot_flicker_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && req.target == ST_BOOT && slave_state == ST_INIT && !(|checks))
		|=> (led_mode == LED_FLICKER && slave_state == ST_INIT && fault.sub_code == SUB_3))
		else $error("boot request fault wrong");
	boot_mailbox_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && req.target == ST_BOOT && slave_state == ST_INIT && checks == 5'b01000)
		|=> (fault.sub_code == SUB_5 && led_mode == LED_BLINK && slave_state == ST_INIT))
		else $error("boot mailbox fault wrong");
	preop_mailbox_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.sm_mailbox_bad && slave_state == ST_PREOP && !checks.firmware_mismatch)
		|=> (slave_state == ST_INIT && fault.sub_code == SUB_6 && fault.main_code == MAIN_81))
		else $error("preop mailbox fault wrong");
	preop_blink_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.sm_mailbox_bad && slave_state == ST_PREOP) |=> (led_mode == LED_BLINK))
		else $error("preop mailbox led wrong");
	firmware_stay_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.firmware_mismatch && (slave_state == ST_BOOT || slave_state == ST_INIT))
		|=> (slave_state == $past(slave_state) && led_mode == LED_OFF && fault.sub_code == SUB_4))
		else $error("firmware fault wrong");
	write_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.file_write_fail && !checks.firmware_mismatch && slave_state == ST_BOOT)
		|=> (fault.main_code == MAIN_80 && fault.sub_code == SUB_5 && slave_state == ST_BOOT))
		else $error("write failure fault wrong");
	desc_mismatch_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.description_mismatch && !checks.firmware_mismatch && slave_state == ST_INIT)
		|=> (fault.main_code == MAIN_80 && fault.sub_code == SUB_6 && slave_state == ST_INIT))
		else $error("description fault wrong");
	desc_led_a: assert property (@(posedge clk) disable iff (!arst_n)
		(checks.description_mismatch && !checks.firmware_mismatch && slave_state == ST_INIT) |=> (led_mode == LED_OFF))
		else $error("description fault led wrong");
	fault_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		(fault.active && !fault_clear && !next_fault_pulse) |=> $stable(fault) && display[19:15] == CH_E)
		else $error("fault code not held");
	clear_loses_a: assert property (@(posedge clk) disable iff (!arst_n)
		(fault_clear && next_fault_pulse) |=> (fault.active && fault_pulse))
		else $error("clear beat a new fault");
	clear_empties_a: assert property (@(posedge clk) disable iff (!arst_n)
		(fault_clear && !next_fault_pulse) |=> (!fault.active && led_mode == LED_OFF && display == {4{CH_BLANK}}))
		else $error("clear did not empty the fault");
	display_code_a: assert property (@(posedge clk) disable iff (!arst_n)
		fault.active |-> (display == {CH_E, CH_R, 1'b0, fault.main_code[7:4], 1'b0, fault.sub_code}))
		else $error("display does not show the fault");
	pulse_active_a: assert property (@(posedge clk) disable iff (!arst_n)
		fault_pulse |-> fault.active)
		else $error("fault pulse without held fault");
	illegal_code_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && known && !legal && !(|checks) && slave_state != ST_OP)
		|=> (fault.sub_code == SUB_1 && slave_state == $past(slave_state) && led_mode == LED_BLINK))
		else $error("illegal request not reported");
	legal_move_a: assert property (@(posedge clk) disable iff (!arst_n)
		(req.valid && known && legal && !(|checks) && !(slave_state == ST_INIT && req.target == ST_BOOT))
		|=> (slave_state == $past(req.target) && !fault_pulse))
		else $error("legal request refused");
endmodule : fieldbus_state_fault_reporter

//--- fault_reporter_pkg.sv
// Package with state codes, fault codes, LED patterns and display format for the fault reporter
package fault_reporter_pkg;
	localparam logic [3:0] ST_INIT = 4'h1;
	localparam logic [3:0] ST_PREOP = 4'h2;
	localparam logic [3:0] ST_BOOT = 4'h3;
	localparam logic [3:0] ST_SAFEOP = 4'h4;
	localparam logic [3:0] ST_OP = 4'h8;

	localparam logic [7:0] MAIN_80 = 8'h80;
	localparam logic [7:0] MAIN_81 = 8'h81;
	localparam logic [3:0] SUB_1 = 4'h1;
	localparam logic [3:0] SUB_2 = 4'h2;
	localparam logic [3:0] SUB_3 = 4'h3;
	localparam logic [3:0] SUB_4 = 4'h4;
	localparam logic [3:0] SUB_5 = 4'h5;
	localparam logic [3:0] SUB_6 = 4'h6;

	// Seven-segment character codes: hex digits 0..F, then E, r, blank
	localparam logic [4:0] CH_E = 5'h10;
	localparam logic [4:0] CH_R = 5'h11;
	localparam logic [4:0] CH_BLANK = 5'h12;

	typedef enum logic [1:0] {LED_OFF, LED_BLINK, LED_FLICKER} led_mode_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] target;
	} state_req_t;

	typedef struct packed {
		logic       firmware_mismatch;
		logic       boot_mailbox_bad;
		logic       sm_mailbox_bad;
		logic       file_write_fail;
		logic       description_mismatch;
	} check_t;

	typedef struct packed {
		logic       active;
		logic [7:0] main_code;
		logic [3:0] sub_code;
	} fault_t;
endpackage : fault_reporter_pkg

//--- fb_master_model.sv
// Master model that issues slave state transition requests
module fb_master_model
(
	output fault_reporter_pkg::state_req_t req
);
	import fault_reporter_pkg::*;
	initial req = '0;
	// Idle cycles carry a moving target so a stale code never looks valid
	task automatic issue(input logic v, input logic [3:0] t);
		req.valid  = v;
		req.target = v ? t : ~req.target;
	endtask : issue
endmodule : fb_master_model

//--- fieldbus_state_fault_reporter_bench.sv
// Self-checking bench for the fieldbus state fault reporter
module fieldbus_state_fault_reporter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import fault_reporter_pkg::*;
	logic        clk, arst_n, clr, p, ep;
	state_req_t  req;
	check_t      c;
	logic [3:0]  st, es;
	fault_t      f, ef;
	led_mode_t   led, el;
	logic [19:0] disp;
	logic [31:0] r;
	logic [3:0]  tab [5] = '{ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_OP};
	int          num_errors, checked, seed;

	fb_master_model m (.req(req));
	fieldbus_state_fault_reporter dut (.clk(clk), .arst_n(arst_n), .req(req), .checks(c),
		.fault_clear(clr), .slave_state(st), .fault(f), .led_mode(led), .display(disp), .fault_pulse(p));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
		checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	function automatic logic legal(input logic [3:0] s, input logic [3:0] t);
		case (s)
			ST_INIT:  return t == ST_INIT || t == ST_PREOP;
			ST_PREOP: return t == ST_INIT || t == ST_PREOP || t == ST_SAFEOP;
			ST_BOOT:  return t == ST_INIT || t == ST_BOOT;
			default:  return t != ST_BOOT;
		endcase
	endfunction : legal

	function automatic logic [3:0] fall(input logic [3:0] s);
		return s == ST_OP ? ST_SAFEOP : s;
	endfunction : fall

	task automatic set(input logic [7:0] mc, input logic [3:0] sc, input led_mode_t l, input logic [3:0] ns);
		ef = '{1'b1, mc, sc};
		el = l;
		es = ns;
		ep = 1'b1;
	endtask : set

	// Compares last cycle's outcome, then drives one cycle and predicts it
	task automatic cyc(input logic v, input logic [3:0] t, input check_t k, input logic cl);
		logic bm;
		@(negedge clk);
		chk("state", 20'(st), 20'(es));
		chk("fault", 20'(f), 20'(ef));
		chk("led", 20'(led), 20'(el));
		chk("pulse", 20'(p), 20'(ep));
		chk("display", disp, ef.active ? {CH_E, CH_R, 1'b0, ef.main_code[7:4], 1'b0, ef.sub_code} : {4{CH_BLANK}});
		m.issue(v, t);
		c = k;
		clr = cl;
		ep = 1'b0;
		bm = k.boot_mailbox_bad;
		if (k.firmware_mismatch && (es == ST_BOOT || es == ST_INIT)) set(MAIN_81, SUB_4, LED_OFF, es);
		else if (k.file_write_fail && es == ST_BOOT) set(MAIN_80, SUB_5, LED_OFF, es);
		else if (k.description_mismatch && es == ST_INIT) set(MAIN_80, SUB_6, LED_OFF, es);
		else if (k.sm_mailbox_bad && es == ST_PREOP) set(MAIN_81, SUB_6, LED_BLINK, ST_INIT);
		else if (v && !(t inside {tab})) set(MAIN_81, SUB_2, LED_BLINK, fall(es));
		else if (v && es == ST_INIT && t == ST_BOOT)
			set(MAIN_81, bm ? SUB_5 : SUB_3, bm ? LED_BLINK : LED_FLICKER, ST_INIT);
		else if (v && !legal(es, t)) set(MAIN_81, SUB_1, LED_BLINK, fall(es));
		else
		begin
			if (v)
				es = t;
			if (cl)
			begin
				ef = '0;
				el = LED_OFF;
			end
		end
	endtask : cyc

	task automatic end_of_test;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	initial
	begin
		#16000;
		num_errors++;
		end_of_test();
	end

	initial
	begin
		seed = 32'h94C5;
		arst_n = 1'b0;
		c = '0;
		clr = 1'b0;
		es = ST_INIT;
		ef = '0;
		el = LED_OFF;
		ep = 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		cyc(1'b1, ST_OP, 5'h00, 1'b0);
		cyc(1'b1, ST_BOOT, 5'h08, 1'b0);
		cyc(1'b1, ST_BOOT, 5'h00, 1'b1);
		cyc(1'b0, 4'h0, 5'h10, 1'b0);
		cyc(1'b0, 4'h0, 5'h01, 1'b0);
		cyc(1'b0, 4'h0, 5'h00, 1'b1);
		cyc(1'b1, ST_PREOP, 5'h00, 1'b0);
		cyc(1'b0, 4'h0, 5'h04, 1'b0);
		cyc(1'b1, ST_PREOP, 5'h00, 1'b0);
		cyc(1'b1, ST_SAFEOP, 5'h00, 1'b0);
		cyc(1'b1, ST_OP, 5'h00, 1'b0);
		cyc(1'b1, ST_BOOT, 5'h00, 1'b0);
		cyc(1'b1, ST_OP, 5'h00, 1'b0);
		cyc(1'b1, 4'hF, 5'h00, 1'b0);
		repeat (3000)
		begin
			r = $random(seed);
			cyc(r[0] | r[1], r[8] & r[9] ? r[15:12] : tab[r[7:5] % 5], r[20:16] & r[25:21] & r[30:26], r[31] & r[2]);
		end
		cyc(1'b0, 4'h0, 5'h00, 1'b0);
		end_of_test();
	end
endmodule : fieldbus_state_fault_reporter_bench
